// [dss_map.svh]
// Register map, field positions, reset values for the debug state sequencer.
// Assumes a 32-bit AHB-Lite slave port; printed offsets are word indexes.
`ifndef DSS_MAP_SVH
`define DSS_MAP_SVH

`define DSS_IDX_W 8
`define DSS_IDX_SEQ_CTL 8'h27
`define DSS_IDX_DBG_CTL 8'h20
`define DSS_IDX_STATUS 8'h21
`define DSS_IDX_CMP_CTL0 8'h30
`define DSS_IDX_NONE 8'hFF
`define DSS_ADDR_SEQ_CTL ({`DSS_IDX_SEQ_CTL, 2'b00})

`define DSS_VIEW_S1 2'h0
`define DSS_VIEW_S2 2'h1
`define DSS_VIEW_S3 2'h2
`define DSS_VIEW_FLAGS 2'h3

`define DSS_BIT_ARM 7
`define DSS_BIT_CMP_EN 0
`define DSS_BIT_CMP_TAG 5
`define DSS_BIT_STAT_ARMED 7

`define DSS_SCR_RST 4'h0
`define DSS_VIEW_RST 2'h0
`define DSS_CMP_RST 8'h00

`endif

// [dss_match_chan.sv]
// One comparator match channel: qualification and sticky session flag.
// Assumes matchIn and tagHit come from logic on mclk.
`timescale 1ns/1ps
module dss_match_chan (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic cmpEnable,
    input wire logic tagMode,
    input wire logic matchIn,
    input wire logic tagHit,
    input wire logic armed,
    input wire logic armPulse,
    output logic qualMatch,
    output logic matchFlag
);
    import dss_pkg::*;

    logic flag_reg;

    // Tagged opcodes only count once they reach execution
    assign qualMatch = cmpEnable && (tagMode ? tagHit : matchIn);

    // A match in the re-arm cycle still sets the flag when armed is already high
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= (armPulse ? 1'b0 : flag_reg) | (armed && qualMatch);
        end
    end

    assign matchFlag = flag_reg;

    property flagHeld_p;
        @(posedge mclk) disable iff (!resetn)
        (flag_reg && !armPulse) |=> flag_reg;
    endproperty
    flag_sticky_a: assert property (flagHeld_p) else $error("match flag dropped within session");

    flag_rearm_a: assert property (@(posedge mclk) disable iff (!resetn)
        (armPulse && !(armed && qualMatch)) |=> !flag_reg) else $error("match flag survived arming");

    chan_enable_a: assert property (@(posedge mclk) disable iff (!resetn)
        !cmpEnable |-> !qualMatch) else $error("disabled channel qualified a match");

    tag_wait_a: assert property (@(posedge mclk) disable iff (!resetn)
        (tagMode && !tagHit) |-> !qualMatch) else $error("tagged match before execution");

endmodule : dss_match_chan

// [dss_match_src.sv]
// Comparator match channel source that stands in front of the sequencer.
// Assumes the bench calls fire() just after a rising mclk edge.
`timescale 1ns/1ps
module dss_match_src (
    input wire logic mclk,
    output logic [2:0] matchIn,
    output logic [2:0] tagHit
);
    initial begin
        matchIn = 3'h0;
        tagHit = 3'h0;
    end

    // One-cycle event, then an idle cycle so two pulses never merge into a level
    task automatic fire(input logic [2:0] m, input logic [2:0] t);
        matchIn <= m;
        tagHit <= t;
        @(posedge mclk);
        matchIn <= 3'h0;
        tagHit <= 3'h0;
        @(posedge mclk);
    endtask : fire
endmodule : dss_match_src

// [dss_pkg.sv]
// Types shared by the debug state sequencer files.
// Assumes the map header is included alongside.
package dss_pkg;

    typedef enum logic [3:0] {
        ST_S1 = 4'h1,
        ST_S2 = 4'h2,
        ST_S3 = 4'h4,
        ST_FIN = 4'h8
    } dss_state_t;

    typedef enum logic [2:0] {
        TG_NONE = 3'h0,
        TG_S1 = 3'h1,
        TG_S2 = 3'h2,
        TG_S3 = 3'h3,
        TG_FIN = 3'h4
    } dss_tgt_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
    } dss_ahb_req_t;

endpackage : dss_pkg

// [dss_state_seq.sv]
// Debug state sequencer: banked next-state control, match flags, AHB-Lite slave.
// Assumes match and tag-hit inputs are synchronous to mclk.
`timescale 1ns/1ps
`include "dss_map.svh"
module dss_state_seq (
    input wire logic mclk,
    input wire logic resetn,
    input dss_pkg::dss_ahb_req_t ahbReq,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [2:0] matchIn,
    input wire logic [2:0] tagHit
);
    import dss_pkg::*;

    logic [3:0] scr_reg [3];
    logic [1:0] view_reg;
    logic armed_reg;
    logic [7:0] cmpCtl_reg [3];
    dss_state_t state_reg;
    dss_state_t state_next;
    logic wrPend_reg;
    logic rdPend_reg;
    logic [`DSS_IDX_W-1:0] wrIdx_reg;
    logic [`DSS_IDX_W-1:0] rdIdx_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] readMux;
    logic [`DSS_IDX_W-1:0] addrIdx;
    logic addrPhase;
    logic ctlWrite;
    logic armPulse;
    logic [2:0] qualMatch;
    logic [2:0] matchFlag;
    dss_tgt_t chanTgt [3];
    dss_tgt_t winTgt;
    logic [1:0] stIdx;

    // Bus side

    assign addrPhase = ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready;
    assign addrIdx = (ahbReq.haddr[31:10] == 22'h0 && ahbReq.haddr[1:0] == 2'h0)
        ? ahbReq.haddr[9:2] : `DSS_IDX_NONE;

    // Reads take one wait state so a write landing just before is seen
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wrPend_reg <= 1'b0;
            rdPend_reg <= 1'b0;
            wrIdx_reg <= `DSS_IDX_NONE;
            rdIdx_reg <= `DSS_IDX_NONE;
        end else begin
            wrPend_reg <= addrPhase && ahbReq.hwrite;
            rdPend_reg <= addrPhase && !ahbReq.hwrite;
            if (addrPhase) begin
                wrIdx_reg <= addrIdx;
                rdIdx_reg <= addrIdx;
            end
        end
    end

    assign hreadyout = !rdPend_reg;
    assign hresp = 1'b0;

    always_comb begin
        readMux = 32'h0;
        case (rdIdx_reg)
            `DSS_IDX_SEQ_CTL: begin
                if (view_reg == `DSS_VIEW_FLAGS) begin
                    readMux[2:0] = matchFlag;
                end else begin
                    readMux[3:0] = scr_reg[view_reg];
                end
            end
            `DSS_IDX_DBG_CTL: begin
                readMux[`DSS_BIT_ARM] = armed_reg;
                readMux[1:0] = view_reg;
            end
            `DSS_IDX_STATUS: begin
                readMux[`DSS_BIT_STAT_ARMED] = armed_reg;
                readMux[3:0] = state_reg;
            end
            `DSS_IDX_CMP_CTL0: begin
                readMux[7:0] = cmpCtl_reg[0];
            end
            `DSS_IDX_CMP_CTL0 + 8'h1: begin
                readMux[7:0] = cmpCtl_reg[1];
            end
            `DSS_IDX_CMP_CTL0 + 8'h2: begin
                readMux[7:0] = cmpCtl_reg[2];
            end
            default: begin
                readMux = 32'h0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hrdata_reg <= 32'h0;
        end else if (rdPend_reg) begin
            hrdata_reg <= readMux;
        end
    end

    assign hrdata = hrdata_reg;

    // Control registers

    assign ctlWrite = wrPend_reg && (wrIdx_reg == `DSS_IDX_DBG_CTL);
    assign armPulse = ctlWrite && hwdata[`DSS_BIT_ARM];

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            view_reg <= `DSS_VIEW_RST;
        end else if (ctlWrite) begin
            view_reg <= hwdata[1:0];
        end
    end

    // Reaching final ends the session; a fresh arm write wins over it
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            armed_reg <= 1'b0;
        end else if (armPulse) begin
            armed_reg <= 1'b1;
        end else if (ctlWrite || state_next == ST_FIN) begin
            armed_reg <= 1'b0;
        end
    end

    // Flag view has no storage behind it, so writes there fall away
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 3; i++) begin
                scr_reg[i] <= `DSS_SCR_RST;
            end
        end else if (wrPend_reg && wrIdx_reg == `DSS_IDX_SEQ_CTL && !armed_reg
                     && view_reg != `DSS_VIEW_FLAGS) begin
            scr_reg[view_reg] <= hwdata[3:0];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 3; i++) begin
                cmpCtl_reg[i] <= `DSS_CMP_RST;
            end
        end else if (wrPend_reg && !armed_reg) begin
            for (int i = 0; i < 3; i++) begin
                if (wrIdx_reg == `DSS_IDX_CMP_CTL0 + 8'(i)) begin
                    cmpCtl_reg[i] <= hwdata[7:0];
                end
            end
        end
    end

    // Match channels

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gChan
            dss_match_chan uChan (
                .mclk(mclk),
                .resetn(resetn),
                .cmpEnable(cmpCtl_reg[g][`DSS_BIT_CMP_EN]),
                .tagMode(cmpCtl_reg[g][`DSS_BIT_CMP_TAG]),
                .matchIn(matchIn[g]),
                .tagHit(tagHit[g]),
                .armed(armed_reg),
                .armPulse(armPulse),
                .qualMatch(qualMatch[g]),
                .matchFlag(matchFlag[g])
            );
        end
    endgenerate

    // Next-state decode

    function automatic void lookup(
        input logic [1:0] st,
        input logic [3:0] code,
        output dss_tgt_t t0,
        output dss_tgt_t t1,
        output dss_tgt_t t2
    );
        t0 = TG_NONE;
        t1 = TG_NONE;
        t2 = TG_NONE;
        case ({st, code})
            6'h00: begin
                t0 = TG_FIN;
                t1 = TG_FIN;
                t2 = TG_FIN;
            end
            6'h01: t1 = TG_S3;
            6'h02: t2 = TG_S2;
            6'h03: t1 = TG_S2;
            6'h04: begin
                t0 = TG_S2;
                t1 = TG_S3;
            end
            6'h05: begin
                t1 = TG_S3;
                t0 = TG_FIN;
            end
            6'h06: begin
                t0 = TG_S2;
                t2 = TG_S3;
            end
            6'h07: begin
                t0 = TG_S2;
                t1 = TG_S2;
            end
            6'h09: t0 = TG_S3;
            6'h0D: begin
                t0 = TG_FIN;
                t2 = TG_FIN;
                t1 = TG_S2;
            end
            6'h10: begin
                t0 = TG_S1;
                t2 = TG_S3;
            end
            6'h11: t1 = TG_S3;
            6'h12: t2 = TG_S3;
            6'h13: begin
                t1 = TG_S3;
                t0 = TG_FIN;
            end
            6'h14: begin
                t1 = TG_S1;
                t2 = TG_S3;
            end
            6'h15: t2 = TG_FIN;
            6'h16: begin
                t2 = TG_S1;
                t0 = TG_FIN;
            end
            6'h17: begin
                t0 = TG_FIN;
                t1 = TG_FIN;
            end
            6'h1C: begin
                t0 = TG_FIN;
                t1 = TG_FIN;
                t2 = TG_S3;
            end
            6'h1F: begin
                t0 = TG_FIN;
                t1 = TG_FIN;
                t2 = TG_S1;
            end
            6'h20: t0 = TG_S1;
            6'h21: begin
                t2 = TG_S2;
                t1 = TG_FIN;
            end
            6'h22: begin
                t0 = TG_FIN;
                t1 = TG_S1;
            end
            6'h23: begin
                t1 = TG_FIN;
                t2 = TG_S1;
            end
            6'h24: t1 = TG_S2;
            6'h25: t1 = TG_FIN;
            6'h26: begin
                t2 = TG_S2;
                t0 = TG_FIN;
            end
            6'h27: t0 = TG_FIN;
            6'h2A: begin
                t1 = TG_S1;
                t2 = TG_S1;
                t0 = TG_FIN;
            end
            6'h2D: begin
                t1 = TG_FIN;
                t2 = TG_FIN;
                t0 = TG_S1;
            end
            6'h2E: begin
                t0 = TG_S2;
                t2 = TG_FIN;
            end
            default: t0 = TG_NONE;
        endcase
    endfunction : lookup

    always_comb begin
        case (state_reg)
            ST_S2: stIdx = 2'h1;
            ST_S3: stIdx = 2'h2;
            default: stIdx = 2'h0;
        endcase
    end

    always_comb begin
        lookup(stIdx, scr_reg[stIdx], chanTgt[0], chanTgt[1], chanTgt[2]);
    end

    // Final target beats all; else the lowest channel that names a target
    always_comb begin
        winTgt = TG_NONE;
        for (int i = 2; i >= 0; i--) begin
            if (qualMatch[i] && chanTgt[i] != TG_NONE) begin
                winTgt = chanTgt[i];
            end
        end
        for (int i = 0; i < 3; i++) begin
            if (qualMatch[i] && chanTgt[i] == TG_FIN) begin
                winTgt = TG_FIN;
            end
        end
    end

    always_comb begin
        state_next = state_reg;
        if (armPulse) begin
            state_next = ST_S1;
        end else if (armed_reg && state_reg != ST_FIN) begin
            case (winTgt)
                TG_S1: state_next = ST_S1;
                TG_S2: state_next = ST_S2;
                TG_S3: state_next = ST_S3;
                TG_FIN: state_next = ST_FIN;
                default: state_next = state_reg;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_S1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Checks

    sequence readData_s;
        rdPend_reg && rdIdx_reg == `DSS_IDX_SEQ_CTL;
    endsequence

    sequence sessionStart_s;
        armPulse;
    endsequence

    view_read_a: assert property (@(posedge mclk) disable iff (!resetn)
        (readData_s and view_reg != `DSS_VIEW_FLAGS) |=> hrdata == {28'h0, $past(scr_reg[view_reg])})
        else $error("shared address shows wrong control register");

    flag_view_a: assert property (@(posedge mclk) disable iff (!resetn)
        (readData_s and view_reg == `DSS_VIEW_FLAGS) |=> hrdata == {29'h0, $past(matchFlag)})
        else $error("flag view returned wrong data");

    armed_lock_a: assert property (@(posedge mclk) disable iff (!resetn)
        (armed_reg && !ctlWrite) |=> ($stable(scr_reg[0]) && $stable(scr_reg[1]) && $stable(scr_reg[2])))
        else $error("control register changed while armed");

    session_arm_a: assert property (@(posedge mclk) disable iff (!resetn)
        sessionStart_s |=> (state_reg == ST_S1 && armed_reg) ##1 (matchFlag & ~$past(qualMatch)) == 3'h0)
        else $error("arming did not start a clean session");

    idle_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
        (qualMatch == 3'h0 && !armPulse) |=> $stable(state_reg))
        else $error("state moved without a match");

    reserved_code_a: assert property (@(posedge mclk) disable iff (!resetn)
        (state_reg == ST_S1 && scr_reg[0] == 4'h8 && !armPulse) |=> $stable(state_reg))
        else $error("reserved code caused a transition");

    final_first_a: assert property (@(posedge mclk) disable iff (!resetn)
        (armed_reg && state_reg == ST_S1 && scr_reg[0] == 4'hD && qualMatch[1:0] == 2'h3 && !armPulse)
        |=> state_reg == ST_FIN) else $error("final target lost priority");

    upper_zero_a: assert property (@(posedge mclk) disable iff (!resetn)
        readData_s |=> hrdata[31:4] == 28'h0) else $error("code register upper bits not zero");

endmodule : dss_state_seq

// [tb_top.sv]
// Self-checking bench for the debug state sequencer over AHB-Lite.
// Assumes byte address = register index * 4, single word transfers, one slave.
`timescale 1ns/1ps
`include "dss_map.svh"
module tb_top;
    import dss_pkg::*;
    localparam logic [31:0] A_SEQ = {22'h0, `DSS_IDX_SEQ_CTL, 2'b00};
    localparam logic [31:0] A_CTL = {22'h0, `DSS_IDX_DBG_CTL, 2'b00};
    localparam logic [31:0] A_STAT = {22'h0, `DSS_IDX_STATUS, 2'b00};
    localparam logic [31:0] A_CMP = {22'h0, `DSS_IDX_CMP_CTL0, 2'b00};
    localparam logic [31:0] A_NONE = {22'h0, `DSS_IDX_NONE, 2'b00};
    logic mclk, resetn, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [2:0] matchIn, tagHit;
    dss_ahb_req_t ahbReq;
    int failures, samplesChecked;
    // Target per channel as status one-hot nibbles {ch2, ch1, ch0}; 0 means no move
    logic [11:0] tbl [3][16];

    assign ahbReq = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: 3'h2, hready: hreadyout};

    dss_state_seq dut (.mclk(mclk), .resetn(resetn), .ahbReq(ahbReq), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .matchIn(matchIn), .tagHit(tagHit));
    dss_match_src src (.mclk(mclk), .matchIn(matchIn), .tagHit(tagHit));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Called just after a rising edge; ready and read data are taken as they stood at each rising edge
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do begin
            @(posedge mclk);
        end while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge mclk);
        end while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : xfer

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask : wr

    task automatic rc(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] x;
        xfer(1'b0, a, 32'h0, x);
        chk(x, e);
    endtask : rc

    // A final target beats everything, otherwise the lowest channel with a target wins
    function automatic logic [3:0] expNext(input int s, input int c, input logic [2:0] m);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 2; i >= 0; i--) begin
            if (m[i] && tbl[s][c][4*i +: 4] != 4'h0) n = tbl[s][c][4*i +: 4];
        end
        for (int i = 0; i < 3; i++) begin
            if (m[i] && tbl[s][c][4*i +: 4] == 4'h8) n = 4'h8;
        end
        return n;
    endfunction : expNext

    task automatic t_reset();
        rc(A_STAT, 32'h1);
        for (int v = 0; v < 4; v++) begin
            wr(A_CTL, 32'(v));
            rc(A_SEQ, 32'h0);
        end
        rc(A_NONE, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_banks();
        for (int v = 0; v < 3; v++) begin
            wr(A_CTL, 32'(v));
            wr(A_SEQ, 32'h5 + 32'(v));
        end
        wr(A_CTL, 32'h3);
        wr(A_SEQ, 32'h7);
        rc(A_SEQ, 32'h0);
        for (int v = 0; v < 3; v++) begin
            wr(A_CTL, 32'h80 | 32'(v));
            wr(A_SEQ, 32'hC);
            rc(A_SEQ, 32'h5 + 32'(v));
        end
        rc(A_CTL, 32'h82);
        rc(A_STAT, 32'h81);
        wr(A_CTL, 32'h0);
        $display("test banks done");
    endtask : t_banks

    task automatic t_qual();
        wr(A_CMP, 32'h21);
        wr(A_CMP + 32'h4, 32'h0);
        wr(A_CMP + 32'h8, 32'h1);
        rc(A_CMP, 32'h21);
        rc(A_CMP + 32'h8, 32'h1);
        wr(A_SEQ, 32'h0);
        wr(A_CTL, 32'h80);
        src.fire(3'h3, 3'h0);
        rc(A_STAT, 32'h81);
        src.fire(3'h0, 3'h1);
        rc(A_STAT, 32'h8);
        wr(A_CMP, 32'h1);
        wr(A_CMP + 32'h4, 32'h1);
        $display("test qualify done");
    endtask : t_qual

    task automatic t_flags();
        wr(A_CTL, 32'h0);
        wr(A_SEQ, 32'h8);
        wr(A_CTL, 32'h80);
        src.fire(3'h1, 3'h0);
        src.fire(3'h5, 3'h0);
        rc(A_STAT, 32'h81);
        wr(A_CTL, 32'h3);
        rc(A_SEQ, 32'h5);
        wr(A_SEQ, 32'h0);
        src.fire(3'h2, 3'h0);
        rc(A_SEQ, 32'h5);
        wr(A_CTL, 32'h83);
        rc(A_SEQ, 32'h0);
        wr(A_CTL, 32'h0);
        $display("test flags done");
    endtask : t_flags

    // Every code of states S1 to S3 against every nonzero match combination, flags read back afterwards
    task automatic t_table();
        logic [3:0] e;
        logic [2:0] nav;
        for (int s = 0; s < 3; s++) begin
            nav = (s == 1) ? 3'h4 : ((s == 2) ? 3'h1 : 3'h0);
            for (int c = 0; c < 16; c++) begin
                for (int m = 1; m < 8; m++) begin
                    wr(A_CTL, 32'h0);
                    wr(A_SEQ, 32'((s == 0) ? c : ((s == 1) ? 2 : 9)));
                    wr(A_CTL, 32'(s));
                    wr(A_SEQ, 32'(c));
                    wr(A_CTL, 32'h80 | 32'(s));
                    if (s > 0) src.fire(nav, 3'h0);
                    src.fire(3'(m), 3'h0);
                    e = expNext(s, c, 3'(m));
                    if (e == 4'h0) e = 4'(1 << s);
                    rc(A_STAT, {24'h0, e != 4'h8, 3'h0, e});
                    wr(A_CTL, 32'h3);
                    rc(A_SEQ, {29'h0, 3'(m) | nav});
                end
            end
        end
        $display("test table done");
    endtask : t_table

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        tbl = '{'{12'h888, 12'h040, 12'h200, 12'h020, 12'h042, 12'h048, 12'h402, 12'h022,
                  12'h000, 12'h004, 12'h000, 12'h000, 12'h000, 12'h828, 12'h000, 12'h000},
                '{12'h401, 12'h040, 12'h400, 12'h048, 12'h410, 12'h800, 12'h108, 12'h088,
                  12'h000, 12'h000, 12'h000, 12'h000, 12'h488, 12'h000, 12'h000, 12'h188},
                '{12'h001, 12'h280, 12'h018, 12'h180, 12'h020, 12'h080, 12'h208, 12'h008,
                  12'h000, 12'h000, 12'h118, 12'h000, 12'h000, 12'h881, 12'h802, 12'h000}};
        failures = 0;
        samplesChecked = 0;
        resetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_banks();
        t_qual();
        t_flags();
        t_table();
        wrap_up();
    end

    // The table sweep needs roughly 7200 cycles; more than five times that means a hang
    initial begin
        repeat (40000) @(posedge mclk);
        failures++;
        wrap_up();
    end
endmodule : tb_top
